// file: hdl/hvl_pin_ctrl.sv
// High-voltage pin 0/1 control: open-drain port, analog routes, LED sink, fault detection
// Operation
// - Port output drives only open-drain pull-down
// - Pin input passed only with buffer enabled
// - Weak pull-up follows its enable bit
// - Attenuator enable routes 1/6 voltage to ADC
// - Sink enabled: PWM channel switches current sink
// - Fault status sampled at PWM period centre
// - Open live reads zero when detect disabled
// - Short live reads zero when detect disabled
// - Filter enable filters fault assert and deassert
// - Short fault sets sticky flag, optional interrupt
// - Open fault sets sticky flag, optional interrupt
// - Divider select: 1/5, 1/3, 1/2, unity
// - Precision current during PWM on, amp to ADC
// - Pin 0 functions each selected by own bit
// - Pin 1 functions each selected by own bit
// - Pins map to port bits and LED channels
// - Five-bit full-scale trim per pin sink
// - Pin 0 separate amp and precision current enables
// - Fault register bit layout as specified
// - Up/down filter counts PWM cycles per fault
`timescale 1ns/1ps

module hvl_pin_ctrl
  import hvl_pkg::*;
#(
  parameter int PINS = HVL_PINS
)
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic [15:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_RD_I,
  output logic [7:0] SFR_RDATA_O,
  input wire logic [PINS-1:0] PORT_OUT_I,
  input wire logic [PINS-1:0] PWM_CH_I,
  input wire logic [PINS-1:0] PWM_CENTER_I,
  input wire logic [PINS-1:0] PIN_I,
  input wire logic [PINS-1:0] OPEN_RAW_I,
  input wire logic [PINS-1:0] SHORT_RAW_I,
  output logic [PINS-1:0] PIN_O,
  output logic [PINS-1:0] PIN_OE_O,
  output logic [PINS-1:0] PIN_IN_O,
  output logic [PINS-1:0] PULLUP_EN_O,
  output logic [PINS-1:0] ATTEN_EN_O,
  output logic [PINS-1:0] BUS_ROUTE_EN_O,
  output logic [PINS-1:0] ANALOG_ROUTE_EN_O,
  output logic [PINS-1:0] SPI_ROUTE_EN_O,
  output logic [PINS-1:0] PORT_FN_EN_O,
  output logic [PINS-1:0] PWM_ROUTE_EN_O,
  output logic [PINS-1:0] SINK_ON_O,
  output logic [PINS*HVL_TRIM_W-1:0] FS_TRIM_O,
  output logic SENSE_AMP_EN_O,
  output logic PRECISION_CURRENT_ON_O,
  output logic [1:0] SENSE_DIV_SEL_O,
  output logic FAULT_IRQ_O
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  hvl_general_s general_reg [PINS];
  hvl_led_s led_reg [PINS];
  hvl_fault_ctl_s fault_ctl_reg [PINS];
  hvl_filter_s filter_reg;
  logic [1:0] divsel_reg;
  logic [PINS-1:0] open_flag_reg;
  logic [PINS-1:0] short_flag_reg;
  logic [PINS-1:0] open_live;
  logic [PINS-1:0] short_live;
  logic [PINS-1:0] pin_stable;
  logic [PINS-1:0] wr_general;
  logic [PINS-1:0] wr_led;
  logic [PINS-1:0] wr_fault;
  logic wr_divsel;
  logic wr_filter;
  logic [7:0] rdata_next;

  // Pin n registers sit at base + 4n (pin 0 base 0xa040)
  always_comb
  begin
    for (int p = 0; p < PINS; p++)
    begin
      wr_general[p] = SFR_WR_I && (SFR_ADDR_I == HVL_ADDR_PIN0_GENERAL + 16'(4 * p));
      wr_led[p] = SFR_WR_I && (SFR_ADDR_I == HVL_ADDR_PIN0_LED + 16'(4 * p));
      wr_fault[p] = SFR_WR_I && (SFR_ADDR_I == HVL_ADDR_PIN0_FAULT + 16'(4 * p));
    end
    wr_divsel = SFR_WR_I && (SFR_ADDR_I == HVL_ADDR_PIN0_DIVSEL);
    wr_filter = SFR_WR_I && (SFR_ADDR_I == HVL_ADDR_FAULT_FILTER);
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      for (int p = 0; p < PINS; p++)
      begin
        general_reg[p] <= HVL_RESET_BYTE;
        led_reg[p] <= HVL_RESET_BYTE;
        fault_ctl_reg[p] <= '0;
      end
      divsel_reg <= '0;
      filter_reg <= HVL_RESET_BYTE;
    end
    else
    begin
      for (int p = 0; p < PINS; p++)
      begin
        if (wr_general[p])
          general_reg[p] <= SFR_WDATA_I;
        if (wr_led[p])
          led_reg[p] <= (p == 0) ? SFR_WDATA_I : (SFR_WDATA_I & HVL_PIN1_LED_MASK);
        if (wr_fault[p])
          fault_ctl_reg[p] <= SFR_WDATA_I[HVL_FB_FILTER:HVL_FB_SHORT_EN];
      end
      if (wr_divsel)
        divsel_reg <= SFR_WDATA_I[1:0];
      if (wr_filter)
        filter_reg <= SFR_WDATA_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-pin input sync, fault filter and sticky flags
  for (genvar g = 0; g < PINS; g++)
  begin : g_pin
    logic [2:0] pin_sync_reg;
    logic [2:0] open_sync_reg;
    logic [2:0] short_sync_reg;
    logic pin_stable_reg;
    logic open_stable_reg;
    logic short_stable_reg;
    logic open_det_reg;
    logic short_det_reg;
    logic [HVL_FILT_W-1:0] open_cnt_reg;
    logic [HVL_FILT_W-1:0] short_cnt_reg;
    logic [HVL_FILT_W-1:0] open_cnt_next;
    logic [HVL_FILT_W-1:0] short_cnt_next;
    logic open_smp;
    logic short_smp;
    logic clr_open;
    logic clr_short;

    // Analog comparators are asynchronous; a change counts once stages 2 and 3 agree
    always_ff @(posedge REF_CLK_I)
    begin
      if (RESET_I)
      begin
        pin_sync_reg <= '0;
        open_sync_reg <= '0;
        short_sync_reg <= '0;
        pin_stable_reg <= 1'b0;
        open_stable_reg <= 1'b0;
        short_stable_reg <= 1'b0;
      end
      else
      begin
        pin_sync_reg <= {pin_sync_reg[1:0], PIN_I[g]};
        open_sync_reg <= {open_sync_reg[1:0], OPEN_RAW_I[g]};
        short_sync_reg <= {short_sync_reg[1:0], SHORT_RAW_I[g]};
        if (pin_sync_reg[1] == pin_sync_reg[2])
          pin_stable_reg <= pin_sync_reg[2];
        if (open_sync_reg[1] == open_sync_reg[2])
          open_stable_reg <= open_sync_reg[2];
        if (short_sync_reg[1] == short_sync_reg[2])
          short_stable_reg <= short_sync_reg[2];
      end
    end

    assign open_smp = open_stable_reg && fault_ctl_reg[g].open_detect_en;
    assign short_smp = short_stable_reg && fault_ctl_reg[g].short_detect_en;
    // Saturating up/down count toward the threshold or toward zero
    always_comb
    begin
      open_cnt_next = open_cnt_reg;
      short_cnt_next = short_cnt_reg;
      if (open_smp && open_cnt_reg < filter_reg.open_filter_count)
        open_cnt_next = open_cnt_reg + 4'h1;
      else if (!open_smp && open_cnt_reg != 4'h0)
        open_cnt_next = open_cnt_reg - 4'h1;
      if (short_smp && short_cnt_reg < filter_reg.short_filter_count)
        short_cnt_next = short_cnt_reg + 4'h1;
      else if (!short_smp && short_cnt_reg != 4'h0)
        short_cnt_next = short_cnt_reg - 4'h1;
    end

    always_ff @(posedge REF_CLK_I)
    begin
      if (RESET_I)
      begin
        open_det_reg <= 1'b0;
        short_det_reg <= 1'b0;
        open_cnt_reg <= '0;
        short_cnt_reg <= '0;
      end
      else if (PWM_CENTER_I[g])
      begin
        if (!fault_ctl_reg[g].fault_filter_en)
        begin
          open_det_reg <= open_smp;
          short_det_reg <= short_smp;
          open_cnt_reg <= '0;
          short_cnt_reg <= '0;
        end
        else
        begin
          open_cnt_reg <= open_cnt_next;
          short_cnt_reg <= short_cnt_next;
          // Hysteresis: assert at threshold, release only at zero
          if (open_smp && open_cnt_next == filter_reg.open_filter_count)
            open_det_reg <= 1'b1;
          else if (!open_smp && open_cnt_next == 4'h0)
            open_det_reg <= 1'b0;
          if (short_smp && short_cnt_next == filter_reg.short_filter_count)
            short_det_reg <= 1'b1;
          else if (!short_smp && short_cnt_next == 4'h0)
            short_det_reg <= 1'b0;
        end
      end
    end

    // Detect enable masks at once, not at the next centre
    assign open_live[g] = open_det_reg && fault_ctl_reg[g].open_detect_en;
    assign short_live[g] = short_det_reg && fault_ctl_reg[g].short_detect_en;
    assign pin_stable[g] = pin_stable_reg;
    assign clr_open = wr_fault[g] && !SFR_WDATA_I[HVL_FB_OPEN_FLAG];
    assign clr_short = wr_fault[g] && !SFR_WDATA_I[HVL_FB_SHORT_FLAG];

    always_ff @(posedge REF_CLK_I)
    begin
      if (RESET_I)
      begin
        open_flag_reg[g] <= 1'b0;
        short_flag_reg[g] <= 1'b0;
      end
      else
      begin
        if (PWM_CENTER_I[g] && open_live[g])
          open_flag_reg[g] <= 1'b1;
        else if (clr_open)
          open_flag_reg[g] <= 1'b0;
        if (PWM_CENTER_I[g] && short_live[g])
          short_flag_reg[g] <= 1'b1;
        else if (clr_short)
          short_flag_reg[g] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path, registered one cycle after the strobe
  always_comb
  begin
    rdata_next = 8'h00;
    for (int p = 0; p < PINS; p++)
    begin
      if (SFR_ADDR_I == HVL_ADDR_PIN0_GENERAL + 16'(4 * p))
        rdata_next = general_reg[p];
      if (SFR_ADDR_I == HVL_ADDR_PIN0_LED + 16'(4 * p))
        rdata_next = led_reg[p];
      if (SFR_ADDR_I == HVL_ADDR_PIN0_FAULT + 16'(4 * p))
        rdata_next = {fault_ctl_reg[p], open_live[p], short_live[p],
                      open_flag_reg[p], short_flag_reg[p]};
    end
    if (SFR_ADDR_I == HVL_ADDR_PIN0_DIVSEL)
      rdata_next = {6'h00, divsel_reg} & HVL_DIVSEL_MASK;
    if (SFR_ADDR_I == HVL_ADDR_FAULT_FILTER)
      rdata_next = filter_reg;
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
      SFR_RDATA_O <= 8'h00;
    else if (SFR_RD_I)
      SFR_RDATA_O <= rdata_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin-facing outputs; index n is port bit n and LED channel n
  always_ff @(posedge REF_CLK_I)
  begin
    if (RESET_I)
    begin
      PIN_O <= '0;
      PIN_OE_O <= '0;
      PIN_IN_O <= '0;
      PULLUP_EN_O <= '0;
      ATTEN_EN_O <= '0;
      BUS_ROUTE_EN_O <= '0;
      ANALOG_ROUTE_EN_O <= '0;
      SPI_ROUTE_EN_O <= '0;
      PORT_FN_EN_O <= '0;
      PWM_ROUTE_EN_O <= '0;
      SINK_ON_O <= '0;
      FS_TRIM_O <= '0;
      SENSE_AMP_EN_O <= 1'b0;
      PRECISION_CURRENT_ON_O <= 1'b0;
      SENSE_DIV_SEL_O <= HVL_DIV_FIFTH;
      FAULT_IRQ_O <= 1'b0;
    end
    else
    begin
      for (int p = 0; p < PINS; p++)
      begin
        // Never drives high: a 1 leaves the pin floating
        PIN_O[p] <= 1'b0;
        PIN_OE_O[p] <= general_reg[p].port_fn_en && !PORT_OUT_I[p];
        PIN_IN_O[p] <= general_reg[p].input_buf_en && pin_stable[p];
        PULLUP_EN_O[p] <= general_reg[p].pullup_en;
        ATTEN_EN_O[p] <= general_reg[p].attenuator_en;
        BUS_ROUTE_EN_O[p] <= general_reg[p].bus_clock_data_route_en;
        ANALOG_ROUTE_EN_O[p] <= general_reg[p].analog_route_en;
        SPI_ROUTE_EN_O[p] <= general_reg[p].spi_route_en;
        PORT_FN_EN_O[p] <= general_reg[p].port_fn_en;
        PWM_ROUTE_EN_O[p] <= general_reg[p].pwm_route_en;
        SINK_ON_O[p] <= led_reg[p].sink_en && PWM_CH_I[p];
        FS_TRIM_O[p*HVL_TRIM_W +: HVL_TRIM_W] <= led_reg[p].fullscale_trim;
      end
      // Attenuator and amp together is a software fault; no interlock here
      SENSE_AMP_EN_O <= led_reg[0].sense_amp_en;
      PRECISION_CURRENT_ON_O <= led_reg[0].precision_current_en && PWM_CH_I[0];
      SENSE_DIV_SEL_O <= divsel_reg;
      FAULT_IRQ_O <= 1'b0;
      for (int p = 0; p < PINS; p++)
      begin
        if (fault_ctl_reg[p].fault_irq_en && (open_flag_reg[p] || short_flag_reg[p]))
          FAULT_IRQ_O <= 1'b1;
      end
    end
  end

endmodule

// file: hdl/hvl_pkg.sv
// Shared constants and config layouts for the high-voltage pin block
package hvl_pkg;

  localparam int HVL_PINS = 2;
  localparam int HVL_TRIM_W = 5;
  localparam int HVL_FILT_W = 4;

  localparam logic [15:0] HVL_ADDR_PIN0_GENERAL = 16'ha040;
  localparam logic [15:0] HVL_ADDR_PIN0_LED = 16'ha041;
  localparam logic [15:0] HVL_ADDR_PIN0_FAULT = 16'ha042;
  localparam logic [15:0] HVL_ADDR_PIN0_DIVSEL = 16'ha043;
  localparam logic [15:0] HVL_ADDR_PIN1_GENERAL = 16'ha044;
  localparam logic [15:0] HVL_ADDR_PIN1_LED = 16'ha045;
  localparam logic [15:0] HVL_ADDR_PIN1_FAULT = 16'ha046;
  localparam logic [15:0] HVL_ADDR_FAULT_FILTER = 16'ha04f;

  localparam logic [7:0] HVL_RESET_BYTE = 8'h00;
  // Pin 1 has no sense amp or precision current bits
  localparam logic [7:0] HVL_PIN1_LED_MASK = 8'h9f;
  localparam logic [7:0] HVL_DIVSEL_MASK = 8'h03;

  // Fault register field positions
  localparam int HVL_FB_FILTER = 7;
  localparam int HVL_FB_IRQ = 6;
  localparam int HVL_FB_OPEN_EN = 5;
  localparam int HVL_FB_SHORT_EN = 4;
  localparam int HVL_FB_OPEN_LIVE = 3;
  localparam int HVL_FB_SHORT_LIVE = 2;
  localparam int HVL_FB_OPEN_FLAG = 1;
  localparam int HVL_FB_SHORT_FLAG = 0;

  // Sense divider encodings: 1/5, 1/3, 1/2, unity
  localparam logic [1:0] HVL_DIV_FIFTH = 2'h0;
  localparam logic [1:0] HVL_DIV_THIRD = 2'h1;
  localparam logic [1:0] HVL_DIV_HALF = 2'h2;
  localparam logic [1:0] HVL_DIV_UNITY = 2'h3;

  typedef struct packed {
    logic bus_clock_data_route_en;
    logic analog_route_en;
    logic spi_route_en;
    logic port_fn_en;
    logic pwm_route_en;
    logic attenuator_en;
    logic input_buf_en;
    logic pullup_en;
  } hvl_general_s;

  typedef struct packed {
    logic sink_en;
    logic sense_amp_en;
    logic precision_current_en;
    logic [4:0] fullscale_trim;
  } hvl_led_s;

  typedef struct packed {
    logic fault_filter_en;
    logic fault_irq_en;
    logic open_detect_en;
    logic short_detect_en;
  } hvl_fault_ctl_s;

  typedef struct packed {
    logic [3:0] open_filter_count;
    logic [3:0] short_filter_count;
  } hvl_filter_s;

endpackage

// file: verification/hvl_led_load.sv
// External LEDs and pin loads facing the high-voltage pins
`timescale 1ns/1ps
module hvl_led_load
  import hvl_pkg::*;
(
  input wire logic clk,
  input wire logic [HVL_PINS-1:0] pin_o,
  input wire logic [HVL_PINS-1:0] pin_oe,
  input wire logic [HVL_PINS-1:0] pullup_en,
  input wire logic [HVL_PINS-1:0] sink_on,
  input wire logic [HVL_PINS-1:0] ext_en,
  input wire logic [HVL_PINS-1:0] ext_level,
  input wire logic [HVL_PINS-1:0] open_led,
  input wire logic [HVL_PINS-1:0] short_led,
  output logic [HVL_PINS-1:0] pin_level,
  output logic [HVL_PINS-1:0] open_cmp,
  output logic [HVL_PINS-1:0] short_cmp
);
  logic flt_reg = 1'b0;
  // Undriven pin wanders rather than holding a friendly level
  always @(posedge clk)
    flt_reg <= ~flt_reg;
  always_comb
  begin
    for (int n = 0; n < HVL_PINS; n++)
    begin
      pin_level[n] = pin_oe[n] ? pin_o[n] : ext_en[n] ? ext_level[n] : pullup_en[n] | flt_reg;
      // Comparators only report while the sink conducts
      open_cmp[n] = open_led[n] & sink_on[n];
      short_cmp[n] = short_led[n] & sink_on[n];
    end
  end
endmodule

// file: verification/hvl_pin_ctrl_assertions.sv
// Port-level checks for the high-voltage pin control block
`timescale 1ns/1ps
module hvl_pin_ctrl_chk
  import hvl_pkg::*;
#(
  parameter int PINS = HVL_PINS
)
(
  input wire logic REF_CLK_I,
  input wire logic RESET_I,
  input wire logic [15:0] SFR_ADDR_I,
  input wire logic SFR_WR_I,
  input wire logic SFR_RD_I,
  input wire logic [7:0] SFR_RDATA_O,
  input wire logic [PINS-1:0] PORT_OUT_I,
  input wire logic [PINS-1:0] PWM_CH_I,
  input wire logic [PINS-1:0] PWM_CENTER_I,
  input wire logic [PINS-1:0] PIN_O,
  input wire logic [PINS-1:0] PIN_OE_O,
  input wire logic [PINS-1:0] PORT_FN_EN_O,
  input wire logic [PINS-1:0] ATTEN_EN_O,
  input wire logic [PINS-1:0] PULLUP_EN_O,
  input wire logic [PINS-1:0] SINK_ON_O,
  input wire logic PRECISION_CURRENT_ON_O,
  input wire logic [1:0] SENSE_DIV_SEL_O,
  input wire logic FAULT_IRQ_O
);
  logic mapped;
  logic any_centre;
  assign mapped = (SFR_ADDR_I >= HVL_ADDR_PIN0_GENERAL && SFR_ADDR_I <= HVL_ADDR_PIN1_FAULT)
    || SFR_ADDR_I == HVL_ADDR_FAULT_FILTER;
  assign any_centre = |PWM_CENTER_I;
  default clocking cb @(posedge REF_CLK_I);
  endclocking
  default disable iff (RESET_I);
  sequence rd_at(logic [15:0] a);
    SFR_RD_I && SFR_ADDR_I == a;
  endsequence
  ////////////////////////////////////////////////////////////////
  open_drain_a: assert property (PIN_O == '0) else $error("pin drove high");
  oe_port_a: assert property (PIN_OE_O == (PORT_FN_EN_O & ~$past(PORT_OUT_I)))
    else $error("drive enable wrong");
  sink_pwm_a: assert property ((SINK_ON_O & ~$past(PWM_CH_I)) == '0)
    else $error("sink on without pwm");
  prec_pwm_a: assert property (PRECISION_CURRENT_ON_O |-> $past(PWM_CH_I[0]))
    else $error("precision current outside pwm");
  rdata_hold_a: assert property (!$past(SFR_RD_I) |-> $stable(SFR_RDATA_O))
    else $error("read data moved");
  unmapped_zero_a: assert property (SFR_RD_I && !mapped |=> SFR_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  divsel_upper_a: assert property (rd_at(HVL_ADDR_PIN0_DIVSEL) |=>
    SFR_RDATA_O[7:2] == 6'h00)
    else $error("divider upper bits set");
  pin1_gap_a: assert property (rd_at(HVL_ADDR_PIN1_LED) |=> SFR_RDATA_O[6:5] == 2'h0)
    else $error("pin1 led gap bits set");
  // Register then output flop: a write shows on the pins two edges later
  cfg_hold_a: assert property (!$past(SFR_WR_I, 2) |->
    $stable(ATTEN_EN_O) && $stable(PULLUP_EN_O) && $stable(SENSE_DIV_SEL_O))
    else $error("config moved without write");
  irq_fall_a: assert property ($fell(FAULT_IRQ_O) |-> $past(SFR_WR_I, 2))
    else $error("irq dropped without write");
  irq_rise_a: assert property ($rose(FAULT_IRQ_O) |->
    $past(any_centre, 2) || $past(SFR_WR_I, 2))
    else $error("irq rose without cause");
endmodule

bind hvl_pin_ctrl hvl_pin_ctrl_chk #(.PINS(PINS)) u_chk (.REF_CLK_I, .RESET_I, .SFR_ADDR_I,
  .SFR_WR_I, .SFR_RD_I, .SFR_RDATA_O, .PORT_OUT_I, .PWM_CH_I, .PWM_CENTER_I, .PIN_O, .PIN_OE_O,
  .PORT_FN_EN_O, .ATTEN_EN_O, .PULLUP_EN_O, .SINK_ON_O, .PRECISION_CURRENT_ON_O,
  .SENSE_DIV_SEL_O, .FAULT_IRQ_O);

// file: verification/testbench.sv
// Self-checking bench for the high-voltage pin control block
`timescale 1ns/1ps
module testbench;
  import hvl_pkg::*;
  logic REF_CLK_I = 1'b0;
  logic RESET_I = 1'b1;
  logic [15:0] SFR_ADDR_I = '0;
  logic SFR_WR_I = 1'b0;
  logic [7:0] SFR_WDATA_I = '0;
  logic SFR_RD_I = 1'b0;
  logic [7:0] SFR_RDATA_O;
  logic [1:0] PORT_OUT_I = '0, PWM_CH_I = '0, PWM_CENTER_I = '0, PIN_I, OPEN_RAW_I, SHORT_RAW_I;
  logic [1:0] PIN_O, PIN_OE_O, PIN_IN_O, PULLUP_EN_O, ATTEN_EN_O, BUS_ROUTE_EN_O;
  logic [1:0] ANALOG_ROUTE_EN_O, SPI_ROUTE_EN_O, PORT_FN_EN_O, PWM_ROUTE_EN_O, SINK_ON_O;
  logic [9:0] FS_TRIM_O;
  logic SENSE_AMP_EN_O, PRECISION_CURRENT_ON_O, FAULT_IRQ_O;
  logic [1:0] SENSE_DIV_SEL_O;
  logic [1:0] ext_en = '0, ext_lvl = '0, f_open = '0, f_short = '0;
  logic [7:0] g[2], l[2], dv, lv, fl;
  logic [15:0] fa;
  logic [6:0] gv;
  int err_count = 0;
  int checks_done = 0;
  int unsigned seed_v;

`define CHK(nm, exp, got) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

  always #4 REF_CLK_I = ~REF_CLK_I;

  hvl_pin_ctrl dut (.REF_CLK_I, .RESET_I, .SFR_ADDR_I, .SFR_WR_I, .SFR_WDATA_I, .SFR_RD_I,
    .SFR_RDATA_O, .PORT_OUT_I, .PWM_CH_I, .PWM_CENTER_I, .PIN_I, .OPEN_RAW_I, .SHORT_RAW_I,
    .PIN_O, .PIN_OE_O, .PIN_IN_O, .PULLUP_EN_O, .ATTEN_EN_O, .BUS_ROUTE_EN_O, .ANALOG_ROUTE_EN_O,
    .SPI_ROUTE_EN_O, .PORT_FN_EN_O, .PWM_ROUTE_EN_O, .SINK_ON_O, .FS_TRIM_O, .SENSE_AMP_EN_O,
    .PRECISION_CURRENT_ON_O, .SENSE_DIV_SEL_O, .FAULT_IRQ_O);
  hvl_led_load u_load (.clk(REF_CLK_I), .pin_o(PIN_O), .pin_oe(PIN_OE_O), .pullup_en(PULLUP_EN_O),
    .sink_on(SINK_ON_O), .ext_en(ext_en), .ext_level(ext_lvl), .open_led(f_open),
    .short_led(f_short), .pin_level(PIN_I), .open_cmp(OPEN_RAW_I), .short_cmp(SHORT_RAW_I));
  ////////////////////////////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(posedge REF_CLK_I);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    SFR_ADDR_I = a;
    SFR_WDATA_I = d;
    SFR_WR_I = 1'b1;
    cyc(1);
    SFR_WR_I = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    SFR_ADDR_I = a;
    SFR_RD_I = 1'b1;
    cyc(1);
    SFR_RD_I = 1'b0;
    `CHK(nm, e, SFR_RDATA_O)
    cyc(1);
  endtask
  task automatic pulse(input int n, input int k);
    repeat (k)
    begin
      PWM_CENTER_I[n] = 1'b1;
      cyc(1);
      PWM_CENTER_I[n] = 1'b0;
      cyc(3);
    end
  endtask
  // Comparator settles through the synchroniser before the next centre
  task automatic flt(input int n, input int k, input logic v);
    if (k == 1)
      f_open[n] = v;
    else
      f_short[n] = v;
    cyc(6);
  endtask
  function automatic logic pin_exp(input logic [7:0] gc, input int n);
    return (gc[4] & ~PORT_OUT_I[n]) ? 1'b0 : ext_en[n] ? ext_lvl[n] : gc[0];
  endfunction
  task automatic results;
    if (err_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    #100000;
    err_count++;
    results();
  end

  initial
  begin
    seed_v = $urandom(24);
    cyc(2);
    RESET_I = 1'b0;
    for (int a = 'ha040; a <= 'ha047; a++)
      rd(16'(a), 8'h00, "reset_val");
    for (int i = 0; i < 16; i++)
    begin
      g[0] = (i == 0) ? 8'hff : 8'($urandom);
      g[1] = (i == 0) ? 8'hff : 8'($urandom);
      l[0] = 8'($urandom);
      l[1] = 8'($urandom);
      dv = {6'($urandom), 2'(i)};
      if (g[0][2])
        l[0][6] = 1'b0;
      PORT_OUT_I = 2'($urandom);
      PWM_CH_I = 2'($urandom);
      ext_lvl = 2'($urandom);
      ext_en = 2'($urandom) | ~{g[1][0], g[0][0]};
      wr(HVL_ADDR_PIN0_GENERAL, g[0]);
      wr(HVL_ADDR_PIN0_LED, l[0]);
      wr(HVL_ADDR_PIN0_DIVSEL, dv);
      wr(HVL_ADDR_PIN1_GENERAL, g[1]);
      wr(HVL_ADDR_PIN1_LED, l[1]);
      wr(16'ha047, 8'hff);
      cyc(6);
      l[1] = l[1] & HVL_PIN1_LED_MASK;
      for (int n = 0; n < 2; n++)
      begin
        gv = {BUS_ROUTE_EN_O[n], ANALOG_ROUTE_EN_O[n], SPI_ROUTE_EN_O[n], PORT_FN_EN_O[n],
          PWM_ROUTE_EN_O[n], ATTEN_EN_O[n], PULLUP_EN_O[n]};
        `CHK("general", {g[n][7:2], g[n][0]}, gv)
        `CHK("drive_en", g[n][4] & ~PORT_OUT_I[n], PIN_OE_O[n])
        `CHK("pin_in", g[n][1] & pin_exp(g[n], n), PIN_IN_O[n])
        `CHK("sink", l[n][7] & PWM_CH_I[n], SINK_ON_O[n])
        `CHK("trim", l[n][4:0], FS_TRIM_O[5*n +: 5])
      end
      `CHK("amp", l[0][6], SENSE_AMP_EN_O)
      `CHK("prec", l[0][5] & PWM_CH_I[0], PRECISION_CURRENT_ON_O)
      `CHK("divsel", dv[1:0], SENSE_DIV_SEL_O)
      rd(HVL_ADDR_PIN0_GENERAL, g[0], "gen0");
      rd(HVL_ADDR_PIN0_LED, l[0], "led0");
      rd(HVL_ADDR_PIN0_DIVSEL, dv & HVL_DIVSEL_MASK, "divsel_rd");
      rd(HVL_ADDR_PIN1_GENERAL, g[1], "gen1");
      rd(HVL_ADDR_PIN1_LED, l[1], "led1");
      rd(16'ha047, 8'h00, "unmapped");
    end
    wr(HVL_ADDR_PIN0_LED, 8'h80);
    wr(HVL_ADDR_PIN1_LED, 8'h80);
    PWM_CH_I = 2'b11;
    for (int n = 0; n < 2; n++)
      for (int k = 0; k < 2; k++)
      begin
        fa = n ? HVL_ADDR_PIN1_FAULT : HVL_ADDR_PIN0_FAULT;
        lv = 8'h04 << k;
        fl = 8'h01 << k;
        wr(fa, 8'h70);
        flt(n, k, 1'b1);
        pulse(n, 1);
        rd(fa, 8'h70 | lv, "live");
        pulse(n, 1);
        rd(fa, 8'h70 | lv | fl, "flag");
        `CHK("irq_on", 1'b1, FAULT_IRQ_O)
        flt(n, k, 1'b0);
        pulse(n, 1);
        wr(fa, 8'h73);
        rd(fa, 8'h70 | fl, "sticky");
        wr(fa, 8'h70);
        rd(fa, 8'h70, "cleared");
        `CHK("irq_off", 1'b0, FAULT_IRQ_O)
        wr(fa, 8'h40);
        flt(n, k, 1'b1);
        pulse(n, 2);
        rd(fa, 8'h40, "masked");
        wr(HVL_ADDR_FAULT_FILTER, 8'h33);
        rd(HVL_ADDR_FAULT_FILTER, 8'h33, "filt_cfg");
        wr(fa, 8'hb0);
        pulse(n, 2);
        rd(fa, 8'hb0, "filt_wait");
        pulse(n, 1);
        rd(fa, 8'hb0 | lv, "filt_hit");
        flt(n, k, 1'b0);
        pulse(n, 2);
        rd(fa, 8'hb0 | lv | fl, "filt_hold");
        `CHK("irq_gate", 1'b0, FAULT_IRQ_O)
        pulse(n, 1);
        rd(fa, 8'hb0 | fl, "filt_rel");
        wr(fa, 8'h00);
      end
    results();
  end
endmodule
